// [dvoc_core.v]
/*
 * deserializer video output conditioning: fifo, spread modulation,
 * staggered colour outputs, edge select, fallback oscillator, sleep and
 * power-down, link status, error count, three white-balance tables.
 * assumes recovered pixel data, lock, embedded-clock presence and fault
 * flags arrive synchronous to clock_i; a register port of the control
 * bus target (already decoded from the serial bus) drives reg_*.
 */
// Contract
// - spread on: both pixel clock and data modulated, up to 2.5 percent, 100 kHz.
// - normal range: select field picks deviation; rate pclk/2168 or pclk/1300.
// - low range: select field picks deviation; rate pclk/628 or pclk/388.
// - red, green and blue output groups switch at different moments.
// - power_down_n high enables; low powers down and disables the link.
// - absent embedded clock bits mean stopped stream; enter sleep.
// - stream restart leaves sleep, relocks and resumes without host action.
// - control registers keep their values through stopped-stream sleep.
// - any of seven cable faults clears link-detect bit 0 at 0x1C.
// - link errors counted, shown in bits 4:0 at 0x41.
// - stream lost with oscillator enable at 0x02 bit 5 drives oscillator clock.
// - fallback oscillator frequency selectable by host.
// - edge select 1 launches for rising capture, 0 for falling; the code launches for rising capture at 0 and for falling at 1.
// - three tables, 256 entries of 8 bits each.
// - white balance on: each component indexes its table, entry replaces it.
// - every table entry writable and readable.
// - tables written over the control bus, device is target.
// - white balance also usable with 18-bit and 16-bit formats.
// - white balance enabled only by a host-written control bit.
// - page bits 7:6 steer accesses: config, red, green, blue.
// - rewrites refused after load unless reload set; updates seamless.
`timescale 1ns/1ps
`include "dvoc_consts.vh"

// ----------------------------------------------------------------
// small fifo, width and depth as parameters
// ----------------------------------------------------------------
module dvoc_fifo #(
   parameter WIDTH = 24,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             clock_i,
   input  wire             reset_i,
   input  wire [WIDTH-1:0] in_data_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   output wire [WIDTH-1:0] out_data_o,
   output wire             out_valid_o,
   input  wire             out_ready_i
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0]    wp_r;
   reg [AW-1:0]    rp_r;
   reg [AW:0]      cnt_r;
   wire            push;
   wire            pop;

   // full and empty come straight from the occupancy count
   assign in_ready_o  = (cnt_r != DEPTH[AW:0]);
   assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
   assign out_data_o  = mem_r[rp_r];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // pointers and count
   always @(posedge clock_i) begin
      if (reset_i) begin
         wp_r  <= {AW{1'b0}};
         rp_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            mem_r[wp_r] <= in_data_i;
            wp_r        <= wp_r + 1'b1;
         end
         if (pop)
            rp_r <= rp_r + 1'b1;
         if (push & ~pop)
            cnt_r <= cnt_r + 1'b1;
         else if (pop & ~push)
            cnt_r <= cnt_r - 1'b1;
      end
   end
endmodule // dvoc_fifo

// ----------------------------------------------------------------
// top level
// ----------------------------------------------------------------
module dvoc_core (
   input  wire        clock_i,
   input  wire        reset_i,
   input  wire        power_down_n_i,
   input  wire        embedded_clk_ok_i,
   input  wire        lock_i,
   input  wire [6:0]  cable_fault_i,
   input  wire        link_error_i,
   input  wire [23:0] pix_data_i,
   input  wire        pix_valid_i,
   output wire        pix_ready_o,
   input  wire        disp_ready_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   input  wire [7:0]  reg_addr_i,
   input  wire [7:0]  reg_wdata_i,
   output reg  [7:0]  reg_rdata_o,
   output wire [7:0]  red_o,
   output wire [7:0]  green_o,
   output wire [7:0]  blue_o,
   output wire        pix_clk_o,
   output wire        out_valid_o,
   output wire        sleep_o,
   output wire        powered_down_o,
   output wire        link_enable_o,
   output wire [2:0]  spread_dev_o
);
   // registers
   reg [7:0]  gen_cfg_r;
   reg [7:0]  ssc_cfg_r;
   reg [7:0]  out_cfg_r;
   reg [7:0]  wb_ctrl_r;
   reg [4:0]  err_cnt_r;
   reg [2:0]  load_done_r;      // per table: last entry 0xff written once
   reg [7:0]  lut_red_r   [0:255];
   reg [7:0]  lut_green_r [0:255];
   reg [7:0]  lut_blue_r  [0:255];
   reg        lock_d_r;
   reg [11:0] ssc_cnt_r;
   reg        ssc_phase_r;
   reg [3:0]  osc_cnt_r;
   reg        osc_clk_r;
   reg        pix_tgl_r;
   reg [7:0]  red_r;
   reg [7:0]  green_d_r [0:`DVOC_STAG_G];
   reg [7:0]  blue_d_r  [0:`DVOC_STAG_B];
   reg        out_valid_r;

   wire       stream_ok;
   wire       active;
   wire [1:0] page;
   wire       wr_cfg;
   wire       lut_wr_ok;
   wire [23:0] fifo_data;
   wire       fifo_valid;
   wire       fifo_pop;
   wire [7:0] r_map;
   wire [7:0] g_map;
   wire [7:0] b_map;
   reg  [11:0] ssc_div;
   reg  [3:0]  osc_half;
   reg  [7:0]  depth_mask;
   integer     i;

   // ----------------------------------------------------------------
   // power and sleep state
   // ----------------------------------------------------------------
   assign powered_down_o = ~power_down_n_i;
   assign stream_ok      = embedded_clk_ok_i;
   assign sleep_o        = power_down_n_i & ~stream_ok;
   // relock is automatic: once clock bits reappear and lock rises we run
   assign active         = power_down_n_i & stream_ok & lock_i;
   assign link_enable_o  = power_down_n_i;

   // ----------------------------------------------------------------
   // register port decode
   // ----------------------------------------------------------------
   assign page    = wb_ctrl_r[7:6];
   assign wr_cfg  = reg_wr_i & (page == `DVOC_PAGE_CFG);
   // a table is writable until its entry 0xff is written, then only with reload
   assign lut_wr_ok = wb_ctrl_r[`DVOC_WB_RELOAD_BIT] |
                      ~load_done_r[page - 2'd1];

   // control registers: no sleep term, so contents ride through sleep
   always @(posedge clock_i) begin
      if (reset_i) begin
         gen_cfg_r <= `DVOC_RST_GEN_CFG;
         ssc_cfg_r <= `DVOC_RST_SSC_CFG;
         out_cfg_r <= `DVOC_RST_OUT_CFG;
         wb_ctrl_r <= `DVOC_RST_WB_CTRL;
      end else if (reg_wr_i) begin
         // the page field is writable only from the config page
         if (reg_addr_i == `DVOC_OFS_WB_CTRL && page == `DVOC_PAGE_CFG)
            wb_ctrl_r <= {reg_wdata_i[7:4], 4'h0};
         if (wr_cfg && reg_addr_i == `DVOC_OFS_GEN_CFG)
            gen_cfg_r <= reg_wdata_i;
         if (wr_cfg && reg_addr_i == `DVOC_OFS_SSC_CFG)
            ssc_cfg_r <= reg_wdata_i;
         if (wr_cfg && reg_addr_i == `DVOC_OFS_OUT_CFG)
            out_cfg_r <= reg_wdata_i;
      end
   end

   // table writes; offset is the entry index; last entry marks the load done
   always @(posedge clock_i) begin
      if (reset_i) begin
         load_done_r <= 3'b000;
      end else if (reg_wr_i && page != `DVOC_PAGE_CFG && lut_wr_ok) begin
         case (page)
            `DVOC_PAGE_RED:   lut_red_r[reg_addr_i]   <= reg_wdata_i;
            `DVOC_PAGE_GREEN: lut_green_r[reg_addr_i] <= reg_wdata_i;
            default:          lut_blue_r[reg_addr_i]  <= reg_wdata_i;
         endcase
         if (reg_addr_i == 8'hFF)
            load_done_r[page - 2'd1] <= 1'b1;
      end
   end

   // read mux, registered; unmapped configuration offsets read zero
   always @(posedge clock_i) begin
      if (reset_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         case (page)
            `DVOC_PAGE_RED:   reg_rdata_o <= lut_red_r[reg_addr_i];
            `DVOC_PAGE_GREEN: reg_rdata_o <= lut_green_r[reg_addr_i];
            `DVOC_PAGE_BLUE:  reg_rdata_o <= lut_blue_r[reg_addr_i];
            default: begin
               case (reg_addr_i)
                  `DVOC_OFS_GEN_CFG:   reg_rdata_o <= gen_cfg_r;
                  `DVOC_OFS_SSC_CFG:   reg_rdata_o <= ssc_cfg_r;
                  `DVOC_OFS_OUT_CFG:   reg_rdata_o <= out_cfg_r;
                  `DVOC_OFS_WB_CTRL:   reg_rdata_o <= wb_ctrl_r;
                  `DVOC_OFS_LINK_STAT:
                     reg_rdata_o <= {7'h00, lock_i & ~(|cable_fault_i)};
                  `DVOC_OFS_ERR_CNT:   reg_rdata_o <= {3'h0, err_cnt_r};
                  default:             reg_rdata_o <= 8'h00;
               endcase
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // link error counter, saturating, cleared by power-down
   // ----------------------------------------------------------------
   always @(posedge clock_i) begin
      if (reset_i || !power_down_n_i)
         err_cnt_r <= 5'h00;
      else if (link_error_i && err_cnt_r != `DVOC_ERR_MAX)
         err_cnt_r <= err_cnt_r + 5'h01;
   end

   // ----------------------------------------------------------------
   // data path: fifo, then lookup, then staggered output groups
   // ----------------------------------------------------------------
   dvoc_fifo #(.WIDTH(24), .DEPTH(4), .AW(2)) u_fifo (
      .clock_i     (clock_i),
      .reset_i     (reset_i),
      .in_data_i   (pix_data_i),
      .in_valid_i  (pix_valid_i),
      .in_ready_o  (pix_ready_o),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop)
   );
   // the display stalls the fifo; pops stop while not active
   assign fifo_pop = disp_ready_i & active;

   // reduced depth keeps only the upper bits: 00 888, 01 666, 10 565
   always @* begin
      case (out_cfg_r[`DVOC_OUT_DEPTH_HI:`DVOC_OUT_DEPTH_LO])
         2'b01:   depth_mask = 8'hFC;
         2'b10:   depth_mask = 8'hF8;
         default: depth_mask = 8'hFF;
      endcase
   end

   // lookup replaces each component when enabled, else passes it
   assign r_map = wb_ctrl_r[`DVOC_WB_EN_BIT] ? lut_red_r[fifo_data[23:16]]
                                             : fifo_data[23:16];
   assign g_map = wb_ctrl_r[`DVOC_WB_EN_BIT] ? lut_green_r[fifo_data[15:8]]
                                             : fifo_data[15:8];
   assign b_map = wb_ctrl_r[`DVOC_WB_EN_BIT] ? lut_blue_r[fifo_data[7:0]]
                                             : fifo_data[7:0];

   // green and blue lag red by one and two cycles when staggering is on
   always @(posedge clock_i) begin
      if (reset_i || !active) begin
         red_r       <= 8'h00;
         out_valid_r <= 1'b0;
         for (i = 0; i <= `DVOC_STAG_B; i = i + 1)
            blue_d_r[i] <= 8'h00;
         for (i = 0; i <= `DVOC_STAG_G; i = i + 1)
            green_d_r[i] <= 8'h00;
      end else begin
         out_valid_r <= fifo_valid & fifo_pop;
         if (fifo_valid & fifo_pop) begin
            red_r        <= r_map & depth_mask;
            green_d_r[0] <= g_map & (out_cfg_r[5] ? 8'hFC : depth_mask);
            blue_d_r[0]  <= b_map & depth_mask;
         end
         for (i = 1; i <= `DVOC_STAG_G; i = i + 1)
            green_d_r[i] <= green_d_r[i-1];
         for (i = 1; i <= `DVOC_STAG_B; i = i + 1)
            blue_d_r[i] <= blue_d_r[i-1];
      end
   end
   assign red_o   = red_r;
   assign green_o = out_cfg_r[`DVOC_OUT_STAG_BIT] ? green_d_r[`DVOC_STAG_G] : green_d_r[0];
   assign blue_o  = out_cfg_r[`DVOC_OUT_STAG_BIT] ? blue_d_r[`DVOC_STAG_B] : blue_d_r[0];
   assign out_valid_o = out_valid_r;

   // ----------------------------------------------------------------
   // spread modulation: triangle phase at pixel clock over divider
   // ----------------------------------------------------------------
   always @* begin
      case ({ssc_cfg_r[`DVOC_SSC_LF_BIT], ssc_cfg_r[2]})
         2'b00:   ssc_div = `DVOC_SSC_DIV_HI0;
         2'b01:   ssc_div = `DVOC_SSC_DIV_HI1;
         2'b10:   ssc_div = `DVOC_SSC_DIV_LO0;
         default: ssc_div = `DVOC_SSC_DIV_LO1;
      endcase
   end

   // phase flips at half the modulation period: up then down sweep
   always @(posedge clock_i) begin
      if (reset_i || !ssc_cfg_r[`DVOC_SSC_EN_BIT]) begin
         ssc_cnt_r   <= 12'd0;
         ssc_phase_r <= 1'b0;
      end else if (ssc_cnt_r >= {1'b0, ssc_div[11:1]} - 12'd1) begin
         ssc_cnt_r   <= 12'd0;
         ssc_phase_r <= ~ssc_phase_r;
      end else begin
         ssc_cnt_r <= ssc_cnt_r + 12'd1;
      end
   end
   // deviation code and sweep direction steer the analog modulator,
   // which shifts the shared output clock so data moves with it
   assign spread_dev_o = ssc_cfg_r[`DVOC_SSC_EN_BIT]
                         ? {ssc_phase_r, ssc_cfg_r[1:0]} : 3'b000;

   // ----------------------------------------------------------------
   // fallback oscillator and output pixel clock with edge select
   // ----------------------------------------------------------------
   always @* begin
      case (out_cfg_r[`DVOC_OUT_OSC_SEL_HI:`DVOC_OUT_OSC_SEL_LO])
         2'b00:   osc_half = `DVOC_OSC_HALF0;
         2'b01:   osc_half = `DVOC_OSC_HALF1;
         2'b10:   osc_half = `DVOC_OSC_HALF2;
         default: osc_half = `DVOC_OSC_HALF3;
      endcase
   end

   always @(posedge clock_i) begin
      if (reset_i) begin
         osc_cnt_r <= 4'd0;
         osc_clk_r <= 1'b0;
      end else if (osc_cnt_r >= osc_half - 4'd1) begin
         osc_cnt_r <= 4'd0;
         osc_clk_r <= ~osc_clk_r;
      end else begin
         osc_cnt_r <= osc_cnt_r + 4'd1;
      end
   end

   // pixel strobe toggles with each new word; polarity picks the edge
   always @(posedge clock_i) begin
      if (reset_i) begin
         pix_tgl_r <= 1'b0;
         lock_d_r  <= 1'b0;
      end else begin
         lock_d_r  <= lock_i;
         pix_tgl_r <= out_valid_r ? ~pix_tgl_r : 1'b0;
      end
   end
   // data changes with the toggle's fall when capture is on the rising edge
   assign pix_clk_o = !power_down_n_i ? 1'b0 :
                      (!stream_ok || !lock_d_r) ?
                         (gen_cfg_r[`DVOC_GEN_OSC_EN_BIT] & osc_clk_r) :
                      (out_cfg_r[`DVOC_OUT_EDGE_BIT] ? ~pix_tgl_r : pix_tgl_r);

endmodule // dvoc_core

// [dvoc_consts.vh]
/*
 * constants for the deserializer video output conditioning block:
 * register offsets, field positions, reset values and timing counts.
 * assumes it is included by its bare name from the design files.
 */
`ifndef DVOC_CONSTS_VH
`define DVOC_CONSTS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses on the 8-bit control port)
// ----------------------------------------------------------------
`define DVOC_OFS_GEN_CFG      8'h02
`define DVOC_OFS_SSC_CFG      8'h2C
`define DVOC_OFS_LINK_STAT    8'h1C
`define DVOC_OFS_ERR_CNT      8'h41
`define DVOC_OFS_WB_CTRL      8'h2A
`define DVOC_OFS_OUT_CFG      8'h03

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DVOC_GEN_OSC_EN_BIT   5
`define DVOC_SSC_LF_BIT       3
`define DVOC_SSC_EN_BIT       4
`define DVOC_OUT_EDGE_BIT     0
`define DVOC_OUT_STAG_BIT     1
`define DVOC_OUT_OSC_SEL_LO   2
`define DVOC_OUT_OSC_SEL_HI   3
`define DVOC_OUT_DEPTH_LO     4
`define DVOC_OUT_DEPTH_HI     5
`define DVOC_WB_EN_BIT        5
`define DVOC_WB_RELOAD_BIT    4
`define DVOC_PAGE_CFG         2'b00
`define DVOC_PAGE_RED         2'b01
`define DVOC_PAGE_GREEN       2'b10
`define DVOC_PAGE_BLUE        2'b11

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DVOC_RST_GEN_CFG      8'h00
`define DVOC_RST_SSC_CFG      8'h00
`define DVOC_RST_OUT_CFG      8'h03
`define DVOC_RST_WB_CTRL      8'h00

// ----------------------------------------------------------------
// spread modulation dividers (pixel clocks per modulation period)
// ----------------------------------------------------------------
`define DVOC_SSC_DIV_HI0      12'd2168
`define DVOC_SSC_DIV_HI1      12'd1300
`define DVOC_SSC_DIV_LO0      12'd628
`define DVOC_SSC_DIV_LO1      12'd388
// fallback oscillator half periods, four selectable rates
`define DVOC_OSC_HALF0        4'd1
`define DVOC_OSC_HALF1        4'd2
`define DVOC_OSC_HALF2        4'd4
`define DVOC_OSC_HALF3        4'd8
// staggered group delays in cycles
`define DVOC_STAG_G           1
`define DVOC_STAG_B           2
// error counter saturation
`define DVOC_ERR_MAX          5'h1F
// lut entries per table
`define DVOC_LUT_DEPTH        256

`endif

// [dvoc_core_asserts.sv]
/* port checker for dvoc_core, attached by bind below.
   assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
module dvoc_core_asserts (
   input wire       clock_i,
   input wire       reset_i,
   input wire       power_down_n_i,
   input wire       embedded_clk_ok_i,
   input wire       lock_i,
   input wire       disp_ready_i,
   input wire       reg_rd_i,
   input wire [7:0] reg_rdata_o,
   input wire [7:0] red_o,
   input wire [7:0] green_o,
   input wire [7:0] blue_o,
   input wire       out_valid_o,
   input wire       sleep_o,
   input wire       powered_down_o,
   input wire       link_enable_o
);
   wire       act = power_down_n_i & embedded_clk_ok_i & lock_i;
   reg  [2:0] act_cnt_r;
   // run of active cycles: inactivity may clear the outputs, so skip those
   always @(posedge clock_i) begin
      if (reset_i || !act) act_cnt_r <= 3'd0;
      else if (act_cnt_r != 3'd7) act_cnt_r <= act_cnt_r + 3'd1;
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   property p_pd; !power_down_n_i |-> powered_down_o && !link_enable_o; endproperty
   a_pd: assert property (p_pd) else $error("power down not shown");
   property p_en; power_down_n_i |-> !powered_down_o && link_enable_o; endproperty
   a_en: assert property (p_en) else $error("enable not shown");
   property p_sleep; sleep_o == (power_down_n_i && !embedded_clk_ok_i); endproperty
   a_sleep: assert property (p_sleep) else $error("sleep state wrong");
   property p_pop;
      out_valid_o |-> $past(disp_ready_i && act) || $past(disp_ready_i && act, 2);
   endproperty
   a_pop: assert property (p_pop) else $error("pixel out while stalled");
   property p_red; $changed(red_o) && act_cnt_r >= 3'd5 |-> out_valid_o; endproperty
   a_red: assert property (p_red) else $error("red moved off its slot");
   property p_grn; $changed(green_o) && act_cnt_r >= 3'd5 |-> $past(out_valid_o); endproperty
   a_grn: assert property (p_grn) else $error("green not one behind");
   property p_blu; $changed(blue_o) && act_cnt_r >= 3'd5 |-> $past(out_valid_o, 2); endproperty
   a_blu: assert property (p_blu) else $error("blue not two behind");
   property p_rd; $changed(reg_rdata_o) |-> $past(reg_rd_i); endproperty
   a_rd: assert property (p_rd) else $error("read data moved without read");
endmodule // dvoc_core_asserts

bind dvoc_core dvoc_core_asserts dvoc_core_asserts_inst (
   .clock_i(clock_i), .reset_i(reset_i), .power_down_n_i(power_down_n_i),
   .embedded_clk_ok_i(embedded_clk_ok_i), .lock_i(lock_i), .disp_ready_i(disp_ready_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .red_o(red_o), .green_o(green_o),
   .blue_o(blue_o), .out_valid_o(out_valid_o), .sleep_o(sleep_o),
   .powered_down_o(powered_down_o), .link_enable_o(link_enable_o)
);

// [dvoc_disp_model.sv]
/* display panel model: takes pixels, stalls at random when asked.
   assumes the bench seeds the random source. */
`timescale 1ns/1ps
module dvoc_disp_model (
   input  wire clock_i,
   input  wire reset_i,
   input  wire stall_en_i,
   output reg  disp_ready_o
);
   // mostly stalled so the queue fills up and refuses
   always @(posedge clock_i) begin
      if (reset_i) disp_ready_o <= 1'b0;
      else disp_ready_o <= !stall_en_i || ($urandom % 4 == 0);
   end
endmodule // dvoc_disp_model

// [dvoc_core_tb.sv]
/* bench for dvoc_core: registers, pixels, sleep, faults, tables.
   assumes the checker and display model are compiled beforehand. */
`timescale 1ns/1ps
`include "dvoc_consts.vh"
module dvoc_core_tb;
   reg        clock_i = 0;
   reg        reset_i = 1;
   reg        power_down_n_i = 0; // low until supplies settle
   reg        embedded_clk_ok_i = 1;
   reg        lock_i = 1;
   reg  [6:0] cable_fault_i = 0;
   reg        link_error_i = 0;
   reg [23:0] pix_data_i = 0;
   reg        pix_valid_i = 0;
   reg        reg_wr_i = 0;
   reg        reg_rd_i = 0;
   reg  [7:0] reg_addr_i = 0;
   reg  [7:0] reg_wdata_i = 0;
   reg        stall_en = 0;
   reg        rd_d = 0;
   reg        ov1 = 0;
   reg        ov2 = 0;
   reg        last;
   reg  [7:0] ta [0:3];
   reg  [7:0] td [0:3];
   reg  [7:0] exp_r [$], exp_g [$], exp_b [$], exp_d [$], exp_m [$];
   wire       disp_ready_i, pix_ready_o, pix_clk_o, out_valid_o;
   wire       sleep_o, powered_down_o, link_enable_o;
   wire [7:0] reg_rdata_o, red_o, green_o, blue_o;
   wire [2:0] spread_dev_o;
   integer    num_errors = 0, num_checks = 0, i, n, w;

   dvoc_core dvoc_core_inst (.clock_i(clock_i), .reset_i(reset_i),
      .power_down_n_i(power_down_n_i), .embedded_clk_ok_i(embedded_clk_ok_i),
      .lock_i(lock_i), .cable_fault_i(cable_fault_i), .link_error_i(link_error_i),
      .pix_data_i(pix_data_i), .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o),
      .disp_ready_i(disp_ready_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .red_o(red_o), .green_o(green_o), .blue_o(blue_o), .pix_clk_o(pix_clk_o),
      .out_valid_o(out_valid_o), .sleep_o(sleep_o), .powered_down_o(powered_down_o),
      .link_enable_o(link_enable_o), .spread_dev_o(spread_dev_o));
   dvoc_disp_model dvoc_disp_model_inst (.clock_i(clock_i), .reset_i(reset_i),
      .stall_en_i(stall_en), .disp_ready_o(disp_ready_i));

   always #12.5 clock_i = ~clock_i;

   task check(input [7:0] seen, input [7:0] want);
      begin
         num_checks = num_checks + 1;
         if (seen !== want) begin
            num_errors = num_errors + 1;
            $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
         end
      end
   endtask
   task conclude;
      begin
         if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // one-cycle strobe, held through the taking edge
   task wr(input [7:0] ad, input [7:0] d);
      begin
         @(posedge clock_i);
         reg_wr_i <= 1'b1;
         reg_addr_i <= ad;
         reg_wdata_i <= d;
         @(posedge clock_i);
         reg_wr_i <= 1'b0;
      end
   endtask
   task rd(input [7:0] ad, input [7:0] want, input [7:0] mask);
      begin
         exp_d.push_back(want);
         exp_m.push_back(mask);
         @(posedge clock_i);
         reg_rd_i <= 1'b1;
         reg_addr_i <= ad;
         @(posedge clock_i);
         reg_rd_i <= 1'b0;
      end
   endtask
   // valid held until ready is seen before the taking edge
   task push(input [23:0] v);
      begin
         exp_r.push_back(v[23:16]);
         exp_g.push_back(v[15:8]);
         exp_b.push_back(v[7:0]);
         @(posedge clock_i);
         pix_valid_i <= 1'b1;
         pix_data_i <= v;
         n = 0;
         @(negedge clock_i);
         while (pix_ready_o !== 1'b1 && n < 300) begin
            @(negedge clock_i);
            n = n + 1;
         end
         @(posedge clock_i);
         pix_valid_i <= 1'b0;
      end
   endtask

   // results are matched against the oldest note; green and blue trail red
   always @(posedge clock_i) begin
      if (rd_d) check(reg_rdata_o & exp_m.pop_front(), exp_d.pop_front());
      if (out_valid_o === 1'b1) check(red_o, exp_r.pop_front());
      if (ov1) check(green_o, exp_g.pop_front());
      if (ov2) check(blue_o, exp_b.pop_front());
      rd_d <= reg_rd_i;
      ov1 <= out_valid_o === 1'b1;
      ov2 <= ov1;
   end

   initial begin
      #1_000_000;
      num_errors = num_errors + 1;
      conclude;
   end

   initial begin
      i = $urandom(36126);
      repeat (20) @(posedge clock_i);
      reset_i <= 1'b0;
      power_down_n_i <= 1'b1;
      rd(`DVOC_OFS_OUT_CFG, `DVOC_RST_OUT_CFG, 8'hFF);
      rd(`DVOC_OFS_GEN_CFG, `DVOC_RST_GEN_CFG, 8'hFF);
      rd(`DVOC_OFS_WB_CTRL, `DVOC_RST_WB_CTRL, 8'hFF);
      rd(8'h55, 8'h00, 8'hFF);
      rd(`DVOC_OFS_LINK_STAT, 8'h01, 8'h01);
      // stalled display: the queue fills, refuses, then drains
      stall_en <= 1'b1;
      repeat (12) push($urandom);
      stall_en <= 1'b0;
      repeat (30) @(posedge clock_i);
      check(exp_b.size(), 8'd0);
      check({7'd0, pix_clk_o}, 8'd1); // idle strobe high
      // every select code in both ranges; upstream clock taken as clean
      for (i = 0; i < 16; i = i + 1) begin
         wr(`DVOC_OFS_SSC_CFG, 8'h10 | i[7:0]);
         repeat (3) @(posedge clock_i);
         @(negedge clock_i);
         check({6'd0, spread_dev_o[1:0]}, {6'd0, i[1:0]});
      end
      // one sweep half per divider: flip to flip spacing
      for (i = 0; i < 4; i = i + 1) begin
         wr(`DVOC_OFS_SSC_CFG, {4'h1, i[1:0], 2'b00});
         w = i == 0 ? `DVOC_SSC_DIV_HI0 : i == 1 ? `DVOC_SSC_DIV_HI1 :
             i == 2 ? `DVOC_SSC_DIV_LO0 : `DVOC_SSC_DIV_LO1;
         @(negedge clock_i);
         last = spread_dev_o[2];
         wait (spread_dev_o[2] !== last);
         @(negedge clock_i);
         for (n = 0; spread_dev_o[2] !== last && n < 2000; n = n + 1)
            @(negedge clock_i);
         check(n[7:0], w[8:1]);
      end
      wr(`DVOC_OFS_SSC_CFG, 8'h0D); // spread off
      repeat (3) @(negedge clock_i);
      check({5'd0, spread_dev_o}, 8'd0);
      // stream lost: fallback clock at each of the four rates
      wr(`DVOC_OFS_GEN_CFG, 8'h20);
      embedded_clk_ok_i <= 1'b0;
      lock_i <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
         wr(`DVOC_OFS_OUT_CFG, {2'b00, i[1:0], 2'b11});
         repeat (20) @(negedge clock_i);
         n = 0;
         last = pix_clk_o;
         repeat (64) begin
            @(negedge clock_i);
            n = n + (pix_clk_o !== last);
            last = pix_clk_o;
         end
         check(n[7:0], 8'd64 >> i);
      end
      wr(`DVOC_OFS_OUT_CFG, `DVOC_RST_OUT_CFG);
      repeat (4) push($urandom);
      @(negedge clock_i);
      check({7'd0, pix_ready_o}, 8'd0); // held full while asleep
      @(posedge clock_i);
      embedded_clk_ok_i <= 1'b1;
      lock_i <= 1'b1;
      rd(`DVOC_OFS_SSC_CFG, 8'h0D, 8'hFF);
      repeat (3) begin
         @(posedge clock_i);
         link_error_i <= 1'b1;
         @(posedge clock_i);
         link_error_i <= 1'b0;
      end
      rd(`DVOC_OFS_ERR_CNT, 8'h03, 8'h1F);
      for (i = 0; i < 7; i = i + 1) begin
         cable_fault_i <= 7'd1 << i;
         repeat (3) @(posedge clock_i);
         rd(`DVOC_OFS_LINK_STAT, 8'h00, 8'h01);
      end
      cable_fault_i <= 7'd0;
      power_down_n_i <= 1'b0;
      repeat (5) @(posedge clock_i);
      power_down_n_i <= 1'b1;
      rd(`DVOC_OFS_ERR_CNT, 8'h00, 8'h1F);
      // red page first; entry 0xff last because it closes the table
      wr(`DVOC_OFS_WB_CTRL, {`DVOC_PAGE_RED, 6'd0});
      for (i = 0; i < 4; i = i + 1) begin
         ta[i] = 8'd16 + i[7:0] * 8'd40 + $urandom % 32;
         td[i] = $urandom;
         wr(ta[i], td[i]);
      end
      wr(8'h05, 8'hA5);
      wr(8'hFF, 8'h3C);
      wr(8'h05, 8'h5A);
      for (i = 0; i < 4; i = i + 1) rd(ta[i], td[i], 8'hFF);
      rd(8'hFF, 8'h3C, 8'hFF);
      rd(8'h05, 8'hA5, 8'hFF); // rewrite refused
      reset_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      reset_i <= 1'b0;
      rd(`DVOC_OFS_WB_CTRL, `DVOC_RST_WB_CTRL, 8'hFF);
      // page leaves a table only through reset; tables keep their contents
      wr(`DVOC_OFS_WB_CTRL, {`DVOC_PAGE_GREEN, 6'd0});
      wr(8'h11, 8'h6B);
      reset_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      reset_i <= 1'b0;
      wr(`DVOC_OFS_WB_CTRL, {`DVOC_PAGE_BLUE, 6'd0});
      wr(8'h22, 8'hC4);
      reset_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      reset_i <= 1'b0;
      wr(`DVOC_OFS_WB_CTRL, 8'h20);
      wr(`DVOC_OFS_OUT_CFG, 8'h13);
      push({ta[0], 8'h11, 8'h22});
      exp_r[0] = td[0] & 8'hFC;
      exp_g[0] = 8'h68;
      exp_b[0] = 8'hC4;
      repeat (8) @(posedge clock_i);
      conclude;
   end
endmodule // dvoc_core_tb
